// *** dv/srh_ctrl_model.sv ***
// Controller model: answers a service request with a serial poll.
// Assumes the bench keeps its own reads away while poll_en is high.
`timescale 1ns/100ps
module srh_ctrl_model (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_b,
  // Device side
  input  wire       srq,
  input  wire       rsp_valid,
  input  wire [15:0] rsp_data,
  output reg        spoll_req,
  // Bench side
  input  wire       poll_en,
  input  wire [3:0] dly,
  output reg  [7:0] polled,
  output reg  [7:0] n_polls
);
  reg       busy;
  reg [3:0] cnt;
  // Drives off the falling edge, like the bench
  always @(negedge clk or negedge rst_b) begin
    if (!rst_b) begin
      spoll_req <= 1'b0;
      busy      <= 1'b0;
      cnt       <= 4'h0;
      polled    <= 8'h00;
      n_polls   <= 8'h00;
    end else begin
      spoll_req <= 1'b0;
      if (busy && rsp_valid) begin
        polled  <= rsp_data[7:0];
        n_polls <= n_polls + 8'h01;
        busy    <= 1'b0;
      end else if (poll_en && srq && !busy) begin
        // Slow controller: dly idle cycles before polling
        if (cnt == dly) begin
          spoll_req <= 1'b1;
          busy      <= 1'b1;
          cnt       <= 4'h0;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule

// *** dv/srh_top_chk.sv ***
// Checker for the status hierarchy top: answer timing, status byte relations.
// Assumes it is bound to srh_top and sees only its ports.
`timescale 1ns/100ps
module srh_top_chk #(
  parameter PW = 16
) (
  input wire          CLK_SYS,
  input wire          RST_B,
  input wire          CMD_RD,
  input wire          SPOLL_REQ,
  input wire          PPOLL_REQ,
  input wire          RSP_VALID,
  input wire [PW-1:0] RSP_DATA,
  input wire          PPOLL_VALID,
  input wire          PPOLL_IST,
  input wire [7:0]    STB,
  input wire          SRQ,
  input wire          IST
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  a_read_answer: assert property (CMD_RD |=> RSP_VALID) else $error("no answer after read");
  a_answer_cause: assert property (RSP_VALID |-> $past(CMD_RD) || $past(SPOLL_REQ)) else $error("stray answer");
  a_spoll_byte: assert property (SPOLL_REQ |=> RSP_VALID && RSP_DATA[15:8] == 8'h00 &&
    (RSP_DATA[7:0] == STB || RSP_DATA[7:0] == $past(STB))) else $error("bad serial poll answer");
  a_ppoll_flag: assert property (PPOLL_REQ |=> PPOLL_VALID &&
    (PPOLL_IST == IST || PPOLL_IST == $past(IST))) else $error("bad parallel poll answer");
  a_ppoll_cause: assert property (PPOLL_VALID |-> $past(PPOLL_REQ)) else $error("stray poll answer");
  a_top_bit_zero: assert property (RSP_VALID |-> !RSP_DATA[15]) else $error("bit 15 set");
  a_data_holds: assert property (!RSP_VALID |-> $stable(RSP_DATA)) else $error("answer data moved");
  a_srq_clear: assert property ($fell(SRQ) |-> $past(SPOLL_REQ)) else $error("request dropped unpolled");
  a_mss_other: assert property (STB[6] |-> (|{STB[7], STB[5:0]}) || $past(|{STB[7], STB[5:0]}))
    else $error("summary bit without cause");
  a_reset_quiet: assert property ($rose(RST_B) |-> STB == 8'h00 && !SRQ && !IST && !RSP_VALID && !PPOLL_VALID)
    else $error("outputs busy after reset");
endmodule
bind srh_top srh_top_chk #(.PW(PW)) srh_top_chk_i (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .CMD_RD(CMD_RD),
  .SPOLL_REQ(SPOLL_REQ), .PPOLL_REQ(PPOLL_REQ), .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA),
  .PPOLL_VALID(PPOLL_VALID), .PPOLL_IST(PPOLL_IST), .STB(STB), .SRQ(SRQ), .IST(IST));

// *** dv/srh_top_tb.sv ***
// Bench for the status hierarchy top: register access, filters, polls.
// Assumes srh_top, its header and the controller model are compiled.
`timescale 1ns/100ps
`include "srh_consts.vh"
module srh_top_tb;
  `define CHK(nm, ex, ac) begin n_compared++; if ((ac) !== (ex)) begin err_count++; \
    $display("wrong value %s exp %0h got %0h", nm, ex, ac); end end
  reg        clk_sys = 0, rst_b = 0, errq_push = 0, errq_not_empty = 0, msg_avail = 0;
  reg        cmd_wr = 0, cmd_rd = 0, ppoll_req = 0, poll_en = 0;
  reg [14:0] oper_cond = 0, ques_cond = 0;
  reg [7:0]  stdev_cond = 0;
  reg [4:0]  cmd_sel = 0;
  reg [15:0] cmd_wdata = 0;
  reg [3:0]  dly = 0;
  wire       spoll_req, rsp_valid, ppoll_valid, ppoll_ist, srq, ist;
  wire [15:0] rsp_data;
  wire [7:0] stb, polled, n_polls;
  int        err_count = 0, n_compared = 0;
  initial forever #2.5 clk_sys = ~clk_sys;
  srh_top srh_top_i (.CLK_SYS(clk_sys), .RST_B(rst_b), .OPER_COND(oper_cond), .QUES_COND(ques_cond),
    .STDEV_COND(stdev_cond), .ERRQ_PUSH(errq_push), .ERRQ_NOT_EMPTY(errq_not_empty), .MSG_AVAIL(msg_avail),
    .CMD_WR(cmd_wr), .CMD_RD(cmd_rd), .CMD_SEL(cmd_sel), .CMD_WDATA(cmd_wdata), .SPOLL_REQ(spoll_req),
    .PPOLL_REQ(ppoll_req), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .PPOLL_VALID(ppoll_valid),
    .PPOLL_IST(ppoll_ist), .STB(stb), .SRQ(srq), .IST(ist));
  srh_ctrl_model srh_ctrl_model_i (.clk(clk_sys), .rst_b(rst_b), .srq(srq), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .spoll_req(spoll_req), .poll_en(poll_en), .dly(dly), .polled(polled), .n_polls(n_polls));
  ////////////////////////////////////////////////////////////
  task cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task wr(input [4:0] s, input [15:0] d);
    @(negedge clk_sys);
    cmd_wr = 1; cmd_sel = s; cmd_wdata = d;
    @(negedge clk_sys);
    cmd_wr = 0;
  endtask
  task rd(input [4:0] s, input [15:0] e);
    @(negedge clk_sys);
    cmd_rd = 1; cmd_sel = s;
    @(negedge clk_sys);
    cmd_rd = 0;
    `CHK("rsp_valid", 1'b1, rsp_valid)
    `CHK("rsp_data", e, rsp_data)
  endtask
  task set_cond(input int r, input [14:0] v);
    case (r)
      0: stdev_cond = v[7:0];
      1: oper_cond = v;
      default: ques_cond = v;
    endcase
  endtask
  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Bounded wait for the controller model to finish a poll
  task wait_polls(input [7:0] t);
    int i;
    for (i = 0; i < 100 && n_polls != t; i++) @(negedge clk_sys);
    if (n_polls != t) begin
      err_count++;
      $display("wrong value n_polls exp %0h got %0h", t, n_polls);
      end_of_test();
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    int r, p, sb;
    reg [4:0] b;
    repeat (20) @(negedge clk_sys);
    rst_b = 1;
    for (p = 0; p < 19; p++) rd(p[4:0], 16'h0000);
    $display("test reset done");
    for (r = 0; r < 3; r++) begin
      b = 5'd4 + 5'd5 * r[4:0];
      sb = (r == 0) ? 5 : (r == 1) ? 7 : 3;
      for (p = 1; p < 5; p++) if (p != 3) begin
        wr(b + p[4:0], 16'hFFFF);
        rd(b + p[4:0], 16'h7FFF);
        rd(b + p[4:0], 16'h7FFF);
        wr(b + p[4:0], 16'h0000);
      end
      wr(b, 16'hFFFF);
      rd(b, 16'h0000);
      wr(b + 5'd1, 16'h0001);
      wr(b + 5'd2, 16'h0002);
      set_cond(r, 15'h0003);
      cyc(6);
      rd(b, 16'h0003);
      rd(b + 5'd3, 16'h0001);
      rd(b + 5'd3, 16'h0000);
      wr(b + 5'd4, 16'h0002);
      wr(`SRH_SEL_SRE, 16'h0040 | (16'h1 << sb));
      wr(`SRH_SEL_PPE, 16'h0040);
      `CHK("stb", 8'h00, stb)
      dly = r * 5;
      poll_en = 1;
      set_cond(r, 15'h0000);
      wait_polls(n_polls + 8'h01);
      poll_en = 0;
      `CHK("polled", 8'h40 | (8'h1 << sb), polled)
      `CHK("srq", 1'b0, srq)
      `CHK("stb", 8'h40 | (8'h1 << sb), stb)
      `CHK("ist", 1'b1, ist)
      ppoll_req = 1;
      cyc(1);
      ppoll_req = 0;
      `CHK("ppoll", 2'b11, {ppoll_valid, ppoll_ist})
      rd(b + 5'd3, 16'h0002);
      cyc(3);
      `CHK("stb", 8'h00, stb)
      `CHK("ist", 1'b0, ist)
      $display("test register %0d done", r);
    end
    wr(`SRH_SEL_SRE, 16'h0004);
    dly = 2;
    poll_en = 1;
    errq_not_empty = 1;
    wait_polls(n_polls + 8'h01);
    `CHK("polled", 8'h44, polled)
    repeat (2) begin
      errq_push = 1;
      cyc(4);
      errq_push = 0;
      wait_polls(n_polls + 8'h01);
    end
    poll_en = 0;
    msg_avail = 1;
    cyc(6);
    `CHK("srq", 1'b0, srq)
    rd(`SRH_SEL_STB, 16'h0054);
    wr(`SRH_SEL_STB, 16'hFFFF);
    rd(`SRH_SEL_SRE, 16'h0004);
    rd(`SRH_SEL_IST, 16'h0001);
    rd(5'h1F, 16'h0000);
    $display("test status byte done");
    end_of_test();
  end
endmodule

// *** hw/srh_consts.vh ***
// Constants for the status reporting hierarchy: command selects,
// status byte bit positions and reset values.
// Assumes inclusion by bare name from the design files.
`ifndef SRH_CONSTS_VH
`define SRH_CONSTS_VH

// Width of a status register part, of the status byte and of a command select
`define SRH_PART_W      16
`define SRH_BYTE_W      8
`define SRH_SEL_W       5

// Command selects, top level
`define SRH_SEL_STB     5'h00
`define SRH_SEL_SRE     5'h01
`define SRH_SEL_PPE     5'h02
`define SRH_SEL_IST     5'h03
// Standard event register parts
`define SRH_SEL_SE_COND 5'h04
`define SRH_SEL_SE_PTR  5'h05
`define SRH_SEL_SE_NTR  5'h06
`define SRH_SEL_SE_EVT  5'h07
`define SRH_SEL_SE_ENA  5'h08
// Operation register parts
`define SRH_SEL_OP_COND 5'h09
`define SRH_SEL_OP_PTR  5'h0A
`define SRH_SEL_OP_NTR  5'h0B
`define SRH_SEL_OP_EVT  5'h0C
`define SRH_SEL_OP_ENA  5'h0D
// Questionable register parts
`define SRH_SEL_QU_COND 5'h0E
`define SRH_SEL_QU_PTR  5'h0F
`define SRH_SEL_QU_NTR  5'h10
`define SRH_SEL_QU_EVT  5'h11
`define SRH_SEL_QU_ENA  5'h12

// Status byte bit positions
`define SRH_STB_ERRQ    2
`define SRH_STB_QUES    3
`define SRH_STB_MAV     4
`define SRH_STB_ESB     5
`define SRH_STB_MSS     6
`define SRH_STB_OPER    7

// Reset values
`define SRH_MASK8_RST   8'h00
`define SRH_MASK15_RST  15'h0000

`endif

// *** hw/srh_part.v ***
// One generic five-part status register: current state, rising and
// falling filters, sticky occurred latch and summary mask.
// Assumes cond_in is already synchronous to clk.
`timescale 1ns/100ps
module srh_part #(
  parameter W = 16
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst_b,
  // Hardware status, top bit absent
  input  wire [W-2:0] cond_in,
  // Host access
  input  wire         wr_ptr,
  input  wire         wr_ntr,
  input  wire         wr_ena,
  input  wire         rd_evt,
  input  wire [W-1:0] wdata,
  // Part contents
  output wire [W-1:0] cond,
  output wire [W-1:0] ptr,
  output wire [W-1:0] ntr,
  output wire [W-1:0] evt,
  output wire [W-1:0] ena,
  output wire         sum
);

reg  [W-2:0] cond_q;
reg  [W-2:0] ptr_q;
reg  [W-2:0] ntr_q;
reg  [W-2:0] evt_q;
reg  [W-2:0] ena_q;
wire [W-2:0] rise;
wire [W-2:0] fall;
wire [W-2:0] next_evt;

////////////////////////////////////////////////////////////////////////
assign rise     = cond_in & ~cond_q & ptr_q;
assign fall     = ~cond_in & cond_q & ntr_q;
// New event wins over a clear in the same cycle
assign next_evt = (rd_evt ? {(W-1){1'b0}} : evt_q) | rise | fall;

always @(posedge clk or negedge rst_b) begin
  if (!rst_b) begin
    cond_q <= {(W-1){1'b0}};
    ptr_q  <= {(W-1){1'b0}};
    ntr_q  <= {(W-1){1'b0}};
    evt_q  <= {(W-1){1'b0}};
    ena_q  <= {(W-1){1'b0}};
  end else begin
    cond_q <= cond_in;
    evt_q  <= next_evt;
    if (wr_ptr) ptr_q <= wdata[W-2:0];
    if (wr_ntr) ntr_q <= wdata[W-2:0];
    if (wr_ena) ena_q <= wdata[W-2:0];
  end
end

////////////////////////////////////////////////////////////////////////
// Same bit number in all parts, top bit always zero
assign cond = {1'b0, cond_q};
assign ptr  = {1'b0, ptr_q};
assign ntr  = {1'b0, ntr_q};
assign evt  = {1'b0, evt_q};
assign ena  = {1'b0, ena_q};
assign sum  = |(evt_q & ena_q);

endmodule

// *** hw/srh_top.v ***
// Status reporting hierarchy: three generic status registers, the
// status byte with its service request and parallel poll masks.
// Assumes status pins are asynchronous and the command port is driven
// by logic on CLK_SYS.
//
// Function
// - Each generic register has five 16-bit parts sharing bit numbers.
// - Bit 15 of every part reads as zero.
// - Current-state part follows hardware, ignores writes, reads are harmless.
// - Rising edge sets event bit when rising filter bit is one.
// - Falling edge sets event bit when falling filter bit is one.
// - Filters and summary mask are read/write; reads leave them unchanged.
// - Event bits latch filtered edges; read-only, cleared by read.
// - Summary bit is OR of event bits ANDed with mask.
// - Summary bits feed current-state bits of the next higher level.
// - Status byte acts as current state; bit 6 summarises others.
// - Service request mask has eight bits; bit 6 is ignored.
// - A masked status byte bit rising raises service request.
// - Bit 2 follows error queue; each new entry may request service.
// - Bit 3 is the questionable register summary.
// - Bit 4 is set while a message is available.
// - Bit 5 is the standard event register summary.
// - Bit 6 set when any other masked status byte bit is set.
// - Bit 7 is the operation register summary.
// - Individual flag is OR of status byte ANDed with poll mask.
// - Status byte returned on query or serial poll.
// - Individual flag returned on parallel poll or query.
// - Service request mask writable and readable, value held.
// - Status byte and its mask form the top of the hierarchy.
`include "srh_consts.vh"
`timescale 1ns/100ps
module srh_top #(
  parameter PW = `SRH_PART_W,
  parameter SW = `SRH_SEL_W
) (
  // Clock and reset
  input  wire          CLK_SYS,
  input  wire          RST_B,
  // Status pins, asynchronous
  input  wire [PW-2:0] OPER_COND,
  input  wire [PW-2:0] QUES_COND,
  input  wire [7:0]    STDEV_COND,
  input  wire          ERRQ_PUSH,
  input  wire          ERRQ_NOT_EMPTY,
  input  wire          MSG_AVAIL,
  // Command port
  input  wire          CMD_WR,
  input  wire          CMD_RD,
  input  wire [SW-1:0] CMD_SEL,
  input  wire [PW-1:0] CMD_WDATA,
  // Poll strobes
  input  wire          SPOLL_REQ,
  input  wire          PPOLL_REQ,
  // Answers
  output reg           RSP_VALID,
  output reg  [PW-1:0] RSP_DATA,
  output reg           PPOLL_VALID,
  output reg           PPOLL_IST,
  // Live status
  output reg  [7:0]    STB,
  output reg           SRQ,
  output reg           IST
);

localparam SYN_W = 2 * (PW - 1) + 8 + 3;

////////////////////////////////////////////////////////////////////////
// Pin synchronisers

reg  [SYN_W-1:0] sync1;
reg  [SYN_W-1:0] sync2;
reg              push_prev;
wire [PW-2:0]    oper_s;
wire [PW-2:0]    ques_s;
wire [7:0]       stdev_s;
wire             push_s;
wire             errq_s;
wire             mav_s;
wire             push_evt;

always @(posedge CLK_SYS or negedge RST_B) begin
  if (!RST_B) begin
    sync1     <= {SYN_W{1'b0}};
    sync2     <= {SYN_W{1'b0}};
    push_prev <= 1'b0;
  end else begin
    sync1     <= {OPER_COND, QUES_COND, STDEV_COND,
                  ERRQ_PUSH, ERRQ_NOT_EMPTY, MSG_AVAIL};
    sync2     <= sync1;
    push_prev <= push_s;
  end
end

assign oper_s   = sync2[SYN_W-1 -: (PW-1)];
assign ques_s   = sync2[SYN_W-PW -: (PW-1)];
assign stdev_s  = sync2[10:3];
assign push_s   = sync2[2];
assign errq_s   = sync2[1];
assign mav_s    = sync2[0];
// One pulse per error queue entry
assign push_evt = push_s & ~push_prev;

////////////////////////////////////////////////////////////////////////
// Command decode

wire wr_se_ptr;
wire wr_se_ntr;
wire wr_se_ena;
wire rd_se_evt;
wire wr_op_ptr;
wire wr_op_ntr;
wire wr_op_ena;
wire rd_op_evt;
wire wr_qu_ptr;
wire wr_qu_ntr;
wire wr_qu_ena;
wire rd_qu_evt;

// Writes to current-state or event selects fall through unused
assign wr_se_ptr = CMD_WR && (CMD_SEL == `SRH_SEL_SE_PTR);
assign wr_se_ntr = CMD_WR && (CMD_SEL == `SRH_SEL_SE_NTR);
assign wr_se_ena = CMD_WR && (CMD_SEL == `SRH_SEL_SE_ENA);
assign rd_se_evt = CMD_RD && (CMD_SEL == `SRH_SEL_SE_EVT);
assign wr_op_ptr = CMD_WR && (CMD_SEL == `SRH_SEL_OP_PTR);
assign wr_op_ntr = CMD_WR && (CMD_SEL == `SRH_SEL_OP_NTR);
assign wr_op_ena = CMD_WR && (CMD_SEL == `SRH_SEL_OP_ENA);
assign rd_op_evt = CMD_RD && (CMD_SEL == `SRH_SEL_OP_EVT);
assign wr_qu_ptr = CMD_WR && (CMD_SEL == `SRH_SEL_QU_PTR);
assign wr_qu_ntr = CMD_WR && (CMD_SEL == `SRH_SEL_QU_NTR);
assign wr_qu_ena = CMD_WR && (CMD_SEL == `SRH_SEL_QU_ENA);
assign rd_qu_evt = CMD_RD && (CMD_SEL == `SRH_SEL_QU_EVT);

////////////////////////////////////////////////////////////////////////
// Lower level registers

wire [PW-1:0] se_cond;
wire [PW-1:0] se_ptr;
wire [PW-1:0] se_ntr;
wire [PW-1:0] se_evt;
wire [PW-1:0] se_ena;
wire          se_sum;
wire [PW-1:0] op_cond;
wire [PW-1:0] op_ptr;
wire [PW-1:0] op_ntr;
wire [PW-1:0] op_evt;
wire [PW-1:0] op_ena;
wire          op_sum;
wire [PW-1:0] qu_cond;
wire [PW-1:0] qu_ptr;
wire [PW-1:0] qu_ntr;
wire [PW-1:0] qu_evt;
wire [PW-1:0] qu_ena;
wire          qu_sum;

srh_part #(.W(PW)) u_stdev (
  .clk     (CLK_SYS),
  .rst_b   (RST_B),
  .cond_in ({{(PW-9){1'b0}}, stdev_s}),
  .wr_ptr  (wr_se_ptr),
  .wr_ntr  (wr_se_ntr),
  .wr_ena  (wr_se_ena),
  .rd_evt  (rd_se_evt),
  .wdata   (CMD_WDATA),
  .cond    (se_cond),
  .ptr     (se_ptr),
  .ntr     (se_ntr),
  .evt     (se_evt),
  .ena     (se_ena),
  .sum     (se_sum)
);

srh_part #(.W(PW)) u_oper (
  .clk     (CLK_SYS),
  .rst_b   (RST_B),
  .cond_in (oper_s),
  .wr_ptr  (wr_op_ptr),
  .wr_ntr  (wr_op_ntr),
  .wr_ena  (wr_op_ena),
  .rd_evt  (rd_op_evt),
  .wdata   (CMD_WDATA),
  .cond    (op_cond),
  .ptr     (op_ptr),
  .ntr     (op_ntr),
  .evt     (op_evt),
  .ena     (op_ena),
  .sum     (op_sum)
);

srh_part #(.W(PW)) u_ques (
  .clk     (CLK_SYS),
  .rst_b   (RST_B),
  .cond_in (ques_s),
  .wr_ptr  (wr_qu_ptr),
  .wr_ntr  (wr_qu_ntr),
  .wr_ena  (wr_qu_ena),
  .rd_evt  (rd_qu_evt),
  .wdata   (CMD_WDATA),
  .cond    (qu_cond),
  .ptr     (qu_ptr),
  .ntr     (qu_ntr),
  .evt     (qu_evt),
  .ena     (qu_ena),
  .sum     (qu_sum)
);

////////////////////////////////////////////////////////////////////////
// Status byte and its masks

reg  [7:0] service_request_mask;
reg  [7:0] parallel_poll_mask;
reg  [7:0] next_stb;
wire [7:0] sre_eff;
wire [7:0] stb_rise;
wire       next_mss;
wire       next_srq;

// Bit 6 of the mask never feeds the request path
assign sre_eff  = service_request_mask & 8'hBF;

always @* begin
  next_stb                = 8'h00;
  next_stb[`SRH_STB_ERRQ] = errq_s;
  next_stb[`SRH_STB_QUES] = qu_sum;
  next_stb[`SRH_STB_MAV]  = mav_s;
  next_stb[`SRH_STB_ESB]  = se_sum;
  next_stb[`SRH_STB_OPER] = op_sum;
  next_stb[`SRH_STB_MSS]  = next_mss;
end

// Summaries enter the status byte as its current state
// Built from the sources, not from next_stb, to keep the path acyclic
assign next_mss = |({op_sum, 1'b0, se_sum, mav_s, qu_sum, errq_s, 2'b00} & sre_eff);
assign stb_rise = next_stb & ~STB & sre_eff;
// Each new error entry requests service on its own when service request mask bit 2 is set
assign next_srq = (|stb_rise) |
                  (push_evt & service_request_mask[`SRH_STB_ERRQ]);

always @(posedge CLK_SYS or negedge RST_B) begin
  if (!RST_B) begin
    STB <= 8'h00;
    service_request_mask <= `SRH_MASK8_RST;
    parallel_poll_mask <= `SRH_MASK8_RST;
    SRQ <= 1'b0;
    IST <= 1'b0;
  end else begin
    STB <= next_stb;
    IST <= |(next_stb & parallel_poll_mask);
    // A new request wins over the serial poll that clears it
    SRQ <= next_srq | (SRQ & ~SPOLL_REQ);
    if (CMD_WR && (CMD_SEL == `SRH_SEL_SRE)) begin
      service_request_mask <= CMD_WDATA[7:0];
    end
    if (CMD_WR && (CMD_SEL == `SRH_SEL_PPE)) begin
      parallel_poll_mask <= CMD_WDATA[7:0];
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Read answers

reg [PW-1:0] rd_mux;

always @* begin
  case (CMD_SEL)
    `SRH_SEL_STB:     rd_mux = {8'h00, STB};
    `SRH_SEL_SRE:     rd_mux = {8'h00, service_request_mask};
    `SRH_SEL_PPE:     rd_mux = {8'h00, parallel_poll_mask};
    `SRH_SEL_IST:     rd_mux = {15'h0000, IST};
    `SRH_SEL_SE_COND: rd_mux = se_cond;
    `SRH_SEL_SE_PTR:  rd_mux = se_ptr;
    `SRH_SEL_SE_NTR:  rd_mux = se_ntr;
    `SRH_SEL_SE_EVT:  rd_mux = se_evt;
    `SRH_SEL_SE_ENA:  rd_mux = se_ena;
    `SRH_SEL_OP_COND: rd_mux = op_cond;
    `SRH_SEL_OP_PTR:  rd_mux = op_ptr;
    `SRH_SEL_OP_NTR:  rd_mux = op_ntr;
    `SRH_SEL_OP_EVT:  rd_mux = op_evt;
    `SRH_SEL_OP_ENA:  rd_mux = op_ena;
    `SRH_SEL_QU_COND: rd_mux = qu_cond;
    `SRH_SEL_QU_PTR:  rd_mux = qu_ptr;
    `SRH_SEL_QU_NTR:  rd_mux = qu_ntr;
    `SRH_SEL_QU_EVT:  rd_mux = qu_evt;
    `SRH_SEL_QU_ENA:  rd_mux = qu_ena;
    default:          rd_mux = 16'h0000;
  endcase
end

// Serial poll takes precedence over a query in the same cycle
always @(posedge CLK_SYS or negedge RST_B) begin
  if (!RST_B) begin
    RSP_VALID   <= 1'b0;
    RSP_DATA    <= 16'h0000;
    PPOLL_VALID <= 1'b0;
    PPOLL_IST   <= 1'b0;
  end else begin
    RSP_VALID   <= CMD_RD | SPOLL_REQ;
    PPOLL_VALID <= PPOLL_REQ;
    if (SPOLL_REQ) begin
      RSP_DATA <= {8'h00, STB};
    end else if (CMD_RD) begin
      RSP_DATA <= rd_mux;
    end
    if (PPOLL_REQ) begin
      PPOLL_IST <= IST;
    end
  end
end

endmodule
